// ===== src/ietu_map.vh
// Summary of operation
// - every instruction finishes in one cycle; trapping opcodes finish by trapping
// - an 8-bit instruction constant may replace the second register operand
// - an unimplemented opcode raises the illegal-opcode trap and changes nothing
// - integer arithmetic updates the status flags; carry chains multi-word sums
// - full multiply, multiply-high and full divide opcodes trap to emulation
// - add-with-carry sum_trap_signed the carry flag; plain add does not
// - subtract-with-borrow is a minus b minus one plus carry
// - signed-checking add and subtract trap out-of-range on signed overflow
// - unsigned-checking add traps on overflow, subtract traps on underflow
// - reverse subtract is b minus a, borrow form and checks alike
// - one-bit multiply steps, signed and unsigned, plus a final step
// - divide support: init, one-bit step, final step, remainder generate
// - compares write a boolean; byte compare true if any byte pair matches
// - assert compares continue if true, else trap to the instruction's vector
// - failed user-mode assert naming vector 0 to 63 traps as protection
// - shifts use a 5-bit count; left and logical right zero-fill
// - funnel extract shifts a 64-bit pair; equal halves make a rotate
// - bitwise logical operations on words update the zero and negative flags
// - floating-point and conversion opcodes trap to software
// - every branch has one delay slot that always executes
// - targets are absolute, pc plus signed offset, or a register
// - conditional jumps test a register boolean; calls write the return
`ifndef IETU_MAP_VH
`define IETU_MAP_VH
`define IETU_CLS_ARITH 3'h0
`define IETU_CLS_STEP 3'h1
`define IETU_CLS_CMP 3'h2
`define IETU_CLS_ASRT 3'h3
`define IETU_CLS_LOGIC 3'h4
`define IETU_CLS_SHIFT 3'h5
`define IETU_CLS_CTL 3'h6
`define IETU_CLS_TRAP 3'h7
// arithmetic sub-fields
`define IETU_CHK_NONE 2'h0
`define IETU_CHK_SIGNED 2'h1
`define IETU_CHK_UNSIGNED 2'h2
`define IETU_KIND_ADD 2'h0
`define IETU_KIND_SUB 2'h1
`define IETU_KIND_RSUB 2'h2
// step class
`define IETU_ST_PRODUCT_SIGNED 5'h00
`define IETU_ST_PRODUCT_UNSIGNED 5'h01
`define IETU_ST_PRODUCT_FINAL 5'h02
`define IETU_ST_QUOT_INIT 5'h03
`define IETU_ST_QUOT_STEP 5'h04
`define IETU_ST_QUOT_FINAL 5'h05
`define IETU_ST_REM_GEN 5'h06
// compare relations
`define IETU_REL_EQ 4'h0
`define IETU_REL_NEQ 4'h1
`define IETU_REL_LT 4'h2
`define IETU_REL_LTU 4'h3
`define IETU_REL_LE 4'h4
`define IETU_REL_LEU 4'h5
`define IETU_REL_GT 4'h6
`define IETU_REL_GTU 4'h7
`define IETU_REL_GE 4'h8
`define IETU_REL_GEU 4'h9
`define IETU_REL_BYTE 4'ha
// logic
`define IETU_LG_AND 5'h00
`define IETU_LG_ANDN 5'h01
`define IETU_LG_NAND 5'h02
`define IETU_LG_OR 5'h03
`define IETU_LG_NOR 5'h04
`define IETU_LG_XOR 5'h05
`define IETU_LG_XNOR 5'h06
// shift
`define IETU_SH_LEFT 2'h0
`define IETU_SH_RLOG 2'h1
`define IETU_SH_RARI 2'h2
`define IETU_SH_FUNNEL 2'h3
// control
`define IETU_CT_CONST_LO 5'h00
`define IETU_CT_CONST_HI 5'h01
`define IETU_CT_JUMP 5'h02
`define IETU_CT_JUMP_FALSE 5'h03
`define IETU_CT_JUMP_TRUE 5'h04
`define IETU_CT_CALL 5'h05
`define IETU_BR_ABS 2'h0
`define IETU_BR_REL 2'h1
`define IETU_BR_REG 2'h2
// trap-only class: low half float, next quarter emulated mul/div
`define IETU_TR_FP_LAST 5'h0f
`define IETU_TR_EMUL_LAST 5'h17
// trap vectors
`define IETU_VEC_ILLEGAL 8'h00
`define IETU_VEC_PROTECT 8'h05
`define IETU_VEC_RANGE 8'h02
`define IETU_VEC_FLOAT 8'h03
`define IETU_VEC_EMUL 8'h04
`define IETU_VEC_USER_LAST 8'h3f
`define IETU_TRUE 32'h8000_0000
`define IETU_FALSE 32'h0000_0000
`define IETU_RET_OFS 32'h0000_0008
`define IETU_ZERO 32'h0000_0000
`endif

// ===== src/ietu_adder.v
`timescale 1ns/1ns
`default_nettype none
module ietu_adder (
  input wire [31:0] a,
  input wire [31:0] b,
  input wire cin,
  output wire [31:0] sum,
  output wire cout,
  output wire ovf
);
  wire [32:0] full;
  assign full = {1'b0, a} + {1'b0, b} + {32'h0000_0000, cin};
  assign sum = full[31:0];
  assign cout = full[32];
  // like-signed inputs giving an opposite-signed sum
  assign ovf = (a[31] == b[31]) && (sum[31] != a[31]);
endmodule
`default_nettype wire

// ===== src/ietu_shifter.v
`timescale 1ns/1ns
`default_nettype none
`include "ietu_map.vh"
module ietu_shifter (
  input wire [31:0] hi,
  input wire [31:0] lo,
  input wire [4:0] amt,
  input wire [1:0] mode,
  output reg [31:0] res
);
  reg [63:0] pair;
  always @*
  begin
    pair = {hi, lo} << amt;
    case (mode)
      `IETU_SH_LEFT: res = hi << amt;
      `IETU_SH_RLOG: res = hi >> amt;
      `IETU_SH_RARI: res = $signed(hi) >>> amt;
      default: res = pair[63:32];
    endcase
  end
endmodule
`default_nettype wire

// ===== src/ietu_core.v
`timescale 1ns/1ns
`default_nettype none
`include "ietu_map.vh"
module ietu_core (
  input wire core_clk,
  input wire resetn,
  input wire issue_valid,
  input wire [7:0] opcode,
  input wire [31:0] first_source_operand,
  input wire [31:0] second_source_operand,
  input wire [7:0] imm8,
  input wire imm_sel,
  input wire [15:0] imm16,
  input wire [4:0] funnel_count,
  input wire [1:0] br_mode,
  input wire [31:0] pc,
  input wire user_mode,
  input wire [7:0] assert_vec,
  output reg done_q,
  output reg [31:0] result_operand_q,
  output reg result_we_q,
  output reg trap_q,
  output reg [7:0] trap_vec_q,
  output reg flag_c_q,
  output reg flag_z_q,
  output reg flag_n_q,
  output reg flag_v_q,
  output reg [31:0] q_reg_q,
  output reg redirect_q,
  output reg [31:0] redirect_pc_q
);
  wire [2:0] cls;
  wire [4:0] sub;
  wire [31:0] a;
  wire [31:0] b;
  assign cls = opcode[7:5];
  assign sub = opcode[4:0];
  assign a = first_source_operand;
  // instruction constant zero-extends into the second operand
  assign b = imm_sel ? {24'h00_0000, imm8} : second_source_operand;

  // shared adder for arithmetic and step operations
  reg [31:0] add_x;
  reg [31:0] add_y;
  reg add_ci;
  wire [31:0] add_s;
  wire add_co;
  wire add_ov;
  ietu_adder u_add (
    .a(add_x),
    .b(add_y),
    .cin(add_ci),
    .sum(add_s),
    .cout(add_co),
    .ovf(add_ov)
  );

  reg [31:0] sh_hi;
  reg [4:0] sh_amt;
  wire [31:0] sh_res;
  ietu_shifter u_sh (
    .hi(sh_hi),
    .lo(b),
    .amt(sh_amt),
    .mode(sub[1:0]),
    .res(sh_res)
  );

  // compare relations
  reg rel;
  wire byte_hit;
  assign byte_hit = (a[7:0] == b[7:0]) || (a[15:8] == b[15:8]) ||
    (a[23:16] == b[23:16]) || (a[31:24] == b[31:24]);
  always @*
  begin
    case (sub[3:0])
      `IETU_REL_EQ: rel = (a == b);
      `IETU_REL_NEQ: rel = (a != b);
      `IETU_REL_LT: rel = ($signed(a) < $signed(b));
      `IETU_REL_LTU: rel = (a < b);
      `IETU_REL_LE: rel = ($signed(a) <= $signed(b));
      `IETU_REL_LEU: rel = (a <= b);
      `IETU_REL_GT: rel = ($signed(a) > $signed(b));
      `IETU_REL_GTU: rel = (a > b);
      `IETU_REL_GE: rel = ($signed(a) >= $signed(b));
      `IETU_REL_GEU: rel = (a >= b);
      default: rel = byte_hit;
    endcase
  end
  wire rel_ok;
  assign rel_ok = (sub[4] == 1'b0) && (sub[3:0] <= `IETU_REL_BYTE);

  // branch target formation
  reg [31:0] tgt;
  always @*
  begin
    case (br_mode)
      `IETU_BR_ABS: tgt = {14'h0000, imm16, 2'h0};
      `IETU_BR_REL: tgt = pc + {{14{imm16[15]}}, imm16, 2'h0};
      default: tgt = b;
    endcase
  end

  // next-state decode
  reg [31:0] res_d;
  reg we_d;
  reg trap_d;
  reg [7:0] vec_d;
  reg upd_arith_d;
  reg upd_logic_d;
  reg [31:0] q_d;
  reg br_d;
  reg [31:0] mul_acc;
  reg [31:0] rem_part;
  reg chk_fail;
  always @*
  begin
    res_d = `IETU_ZERO;
    we_d = 1'b0;
    trap_d = 1'b0;
    vec_d = `IETU_VEC_ILLEGAL;
    upd_arith_d = 1'b0;
    upd_logic_d = 1'b0;
    q_d = q_reg_q;
    br_d = 1'b0;
    add_x = a;
    add_y = b;
    add_ci = 1'b0;
    sh_hi = a;
    sh_amt = b[4:0];
    mul_acc = a;
    rem_part = a;
    chk_fail = 1'b0;
    case (cls)
      `IETU_CLS_ARITH:
      begin
        case (sub[4:3])
          `IETU_KIND_ADD:
          begin
            add_ci = sub[2] & flag_c_q;
          end
          `IETU_KIND_SUB:
          begin
            add_y = ~b;
            // a + ~b + 1 is a - b; with C it is a - b - 1 + C
            add_ci = sub[2] ? flag_c_q : 1'b1;
          end
          default:
          begin
            add_x = b;
            add_y = ~a;
            add_ci = sub[2] ? flag_c_q : 1'b1;
          end
        endcase
        case (sub[1:0])
          `IETU_CHK_SIGNED: chk_fail = add_ov;
          `IETU_CHK_UNSIGNED:
          begin
            // carry out means overflow on add, no carry means underflow
            if (sub[4:3] == `IETU_KIND_ADD)
              chk_fail = add_co;
            else
              chk_fail = ~add_co;
          end
          default: chk_fail = 1'b0;
        endcase
        if ((sub[4:3] == 2'h3) || (sub[1:0] == 2'h3))
        begin
          trap_d = 1'b1;
        end
        else if (chk_fail)
        begin
          trap_d = 1'b1;
          vec_d = `IETU_VEC_RANGE;
        end
        else
        begin
          res_d = add_s;
          we_d = 1'b1;
          upd_arith_d = 1'b1;
        end
      end
      `IETU_CLS_STEP:
      begin
        case (sub)
          `IETU_ST_PRODUCT_SIGNED, `IETU_ST_PRODUCT_UNSIGNED:
          begin
            // multiplier lsb in q picks add or pass
            add_y = q_reg_q[0] ? b : `IETU_ZERO;
            mul_acc = add_s;
            if (sub == `IETU_ST_PRODUCT_SIGNED)
              res_d = {add_s[31] ^ add_ov, add_s[31:1]};
            else
              res_d = {add_co, add_s[31:1]};
            q_d = {mul_acc[0], q_reg_q[31:1]};
            we_d = 1'b1;
            upd_arith_d = 1'b1;
          end
          `IETU_ST_PRODUCT_FINAL:
          begin
            // signed multiplier sign bit is a negative weight
            add_y = q_reg_q[0] ? ~b : `IETU_ZERO;
            add_ci = q_reg_q[0];
            res_d = {add_s[31] ^ add_ov, add_s[31:1]};
            q_d = {add_s[0], q_reg_q[31:1]};
            we_d = 1'b1;
            upd_arith_d = 1'b1;
          end
          `IETU_ST_QUOT_INIT:
          begin
            q_d = b;
            res_d = a;
            we_d = 1'b1;
            upd_arith_d = 1'b1;
          end
          `IETU_ST_QUOT_STEP, `IETU_ST_QUOT_FINAL:
          begin
            // restoring step: remainder gains the next dividend bit
            rem_part = {a[30:0], q_reg_q[31]};
            add_x = rem_part;
            add_y = ~b;
            add_ci = 1'b1;
            if (add_co || a[31])
            begin
              res_d = add_s;
              q_d = {q_reg_q[30:0], 1'b1};
            end
            else
            begin
              res_d = rem_part;
              q_d = {q_reg_q[30:0], 1'b0};
            end
            we_d = 1'b1;
            upd_arith_d = 1'b1;
          end
          `IETU_ST_REM_GEN:
          begin
            // restoring form leaves the remainder whole
            res_d = a;
            we_d = 1'b1;
            upd_arith_d = 1'b1;
          end
          default: trap_d = 1'b1;
        endcase
      end
      `IETU_CLS_CMP:
      begin
        if (rel_ok)
        begin
          res_d = rel ? `IETU_TRUE : `IETU_FALSE;
          we_d = 1'b1;
        end
        else
          trap_d = 1'b1;
      end
      `IETU_CLS_ASRT:
      begin
        if (!rel_ok || (sub[3:0] == `IETU_REL_BYTE))
          trap_d = 1'b1;
        else if (!rel)
        begin
          trap_d = 1'b1;
          if (user_mode && (assert_vec <= `IETU_VEC_USER_LAST))
            vec_d = `IETU_VEC_PROTECT;
          else
            vec_d = assert_vec;
        end
      end
      `IETU_CLS_LOGIC:
      begin
        we_d = 1'b1;
        upd_logic_d = 1'b1;
        case (sub)
          `IETU_LG_AND: res_d = a & b;
          `IETU_LG_ANDN: res_d = a & ~b;
          `IETU_LG_NAND: res_d = ~(a & b);
          `IETU_LG_OR: res_d = a | b;
          `IETU_LG_NOR: res_d = ~(a | b);
          `IETU_LG_XOR: res_d = a ^ b;
          `IETU_LG_XNOR: res_d = ~(a ^ b);
          default:
          begin
            we_d = 1'b0;
            upd_logic_d = 1'b0;
            trap_d = 1'b1;
          end
        endcase
      end
      `IETU_CLS_SHIFT:
      begin
        if (sub[4:2] != 3'h0)
          trap_d = 1'b1;
        else
        begin
          if (sub[1:0] == `IETU_SH_FUNNEL)
            sh_amt = funnel_count;
          res_d = sh_res;
          we_d = 1'b1;
        end
      end
      `IETU_CLS_CTL:
      begin
        case (sub)
          `IETU_CT_CONST_LO:
          begin
            res_d = {16'h0000, imm16};
            we_d = 1'b1;
          end
          `IETU_CT_CONST_HI:
          begin
            res_d = {imm16, a[15:0]};
            we_d = 1'b1;
          end
          `IETU_CT_JUMP: br_d = 1'b1;
          `IETU_CT_JUMP_FALSE: br_d = ~a[31];
          `IETU_CT_JUMP_TRUE: br_d = a[31];
          `IETU_CT_CALL:
          begin
            br_d = 1'b1;
            res_d = pc + `IETU_RET_OFS;
            we_d = 1'b1;
          end
          default: trap_d = 1'b1;
        endcase
      end
      default:
      begin
        trap_d = 1'b1;
        if (sub <= `IETU_TR_FP_LAST)
          vec_d = `IETU_VEC_FLOAT;
        else if (sub <= `IETU_TR_EMUL_LAST)
          vec_d = `IETU_VEC_EMUL;
        else
          vec_d = `IETU_VEC_ILLEGAL;
      end
    endcase
  end

  // a taken branch waits for its delay slot to issue before redirecting
  reg pend_q;
  reg [31:0] pend_pc_q;
  always @(posedge core_clk)
  begin
    if (!resetn)
    begin
      done_q <= 1'b0;
      result_operand_q <= `IETU_ZERO;
      result_we_q <= 1'b0;
      trap_q <= 1'b0;
      trap_vec_q <= `IETU_VEC_ILLEGAL;
      flag_c_q <= 1'b0;
      flag_z_q <= 1'b0;
      flag_n_q <= 1'b0;
      flag_v_q <= 1'b0;
      q_reg_q <= `IETU_ZERO;
      redirect_q <= 1'b0;
      redirect_pc_q <= `IETU_ZERO;
      pend_q <= 1'b0;
      pend_pc_q <= `IETU_ZERO;
    end
    else
    begin
      done_q <= issue_valid;
      result_we_q <= issue_valid & we_d & ~trap_d;
      trap_q <= issue_valid & trap_d;
      redirect_q <= 1'b0;
      if (issue_valid)
      begin
        result_operand_q <= res_d;
        if (trap_d)
          trap_vec_q <= vec_d;
        else
          q_reg_q <= q_d;
        if (upd_arith_d && !trap_d)
        begin
          flag_c_q <= add_co;
          flag_v_q <= add_ov;
          flag_z_q <= (res_d == `IETU_ZERO);
          flag_n_q <= res_d[31];
        end
        else if (upd_logic_d)
        begin
          flag_z_q <= (res_d == `IETU_ZERO);
          flag_n_q <= res_d[31];
        end
        if (pend_q)
        begin
          // the slot instruction has now executed, taken or not
          redirect_q <= 1'b1;
          redirect_pc_q <= pend_pc_q;
          pend_q <= 1'b0;
        end
        else if (br_d && !trap_d)
        begin
          pend_q <= 1'b1;
          pend_pc_q <= tgt;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ===== src/ietu_placeholder_none.v
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

// ===== testbench/ietu_core_properties.sv
`timescale 1ns/1ns
`default_nettype none
`include "ietu_map.vh"
module ietu_core_properties (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic issue_valid,
  input wire logic [7:0] opcode,
  input wire logic [31:0] first_source_operand,
  input wire logic [31:0] second_source_operand,
  input wire logic [7:0] imm8,
  input wire logic imm_sel,
  input wire logic [31:0] pc,
  input wire logic user_mode,
  input wire logic [7:0] assert_vec,
  input wire logic done_q,
  input wire logic [31:0] result_operand_q,
  input wire logic result_we_q,
  input wire logic trap_q,
  input wire logic [7:0] trap_vec_q,
  input wire logic redirect_q
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  wire [31:0] b_eff = imm_sel ? {24'h00_0000, imm8} : second_source_operand;
  wire [2:0] cls = opcode[7:5];
  wire [4:0] sub = opcode[4:0];
  wire jmp = issue_valid && opcode == {`IETU_CLS_CTL, `IETU_CT_JUMP};
  sequence s_fresh_jump;
    jmp && !$past(issue_valid && cls == `IETU_CLS_CTL);
  endsequence
  sequence s_slot;
    issue_valid;
  endsequence
  a_done_follows_issue: assert property (issue_valid |=> done_q)
    else $error("issue without done");
  a_idle_stays_quiet: assert property (!issue_valid |=>
    !done_q && !result_we_q && !trap_q) else $error("output without issue");
  a_trap_no_write: assert property (trap_q |-> !result_we_q)
    else $error("trap with write");
  a_illegal_op_vector: assert property (issue_valid &&
    cls == `IETU_CLS_TRAP && sub > `IETU_TR_EMUL_LAST
    |=> trap_q && trap_vec_q == `IETU_VEC_ILLEGAL) else $error("illegal");
  a_float_op_vector: assert property (issue_valid &&
    cls == `IETU_CLS_TRAP && sub <= `IETU_TR_FP_LAST
    |=> trap_q && trap_vec_q == `IETU_VEC_FLOAT) else $error("float");
  a_emul_op_vector: assert property (issue_valid &&
    cls == `IETU_CLS_TRAP && sub > `IETU_TR_FP_LAST &&
    sub <= `IETU_TR_EMUL_LAST |=> trap_q && trap_vec_q == `IETU_VEC_EMUL)
    else $error("emulation");
  a_user_low_protect: assert property (issue_valid &&
    cls == `IETU_CLS_ASRT && sub < `IETU_REL_BYTE && user_mode &&
    assert_vec <= `IETU_VEC_USER_LAST
    |=> !trap_q || trap_vec_q == `IETU_VEC_PROTECT) else $error("protect");
  a_cmp_writes_bool: assert property (issue_valid &&
    cls == `IETU_CLS_CMP && sub <= `IETU_REL_BYTE
    |=> result_we_q && result_operand_q[30:0] == 0)
    else $error("compare boolean");
  a_plain_add_sum: assert property (issue_valid &&
    opcode == {`IETU_CLS_ARITH, `IETU_KIND_ADD, 1'b0, `IETU_CHK_NONE}
    |=> result_we_q && result_operand_q ==
    $past(first_source_operand) + $past(b_eff)) else $error("add sum");
  a_call_link_addr: assert property (issue_valid &&
    opcode == {`IETU_CLS_CTL, `IETU_CT_CALL} |=> result_we_q &&
    result_operand_q == $past(pc) + `IETU_RET_OFS) else $error("call link");
  a_slot_then_redir: assert property (s_fresh_jump ##1 s_slot
    |=> redirect_q) else $error("no redirect after slot");
  a_no_early_redir: assert property (s_fresh_jump |=> !redirect_q)
    else $error("redirect before slot");
endmodule
bind ietu_core ietu_core_properties i_ietu_core_properties (
  .core_clk(core_clk), .resetn(resetn), .issue_valid(issue_valid),
  .opcode(opcode), .first_source_operand(first_source_operand),
  .second_source_operand(second_source_operand), .imm8(imm8),
  .imm_sel(imm_sel), .pc(pc), .user_mode(user_mode),
  .assert_vec(assert_vec), .done_q(done_q),
  .result_operand_q(result_operand_q), .result_we_q(result_we_q),
  .trap_q(trap_q), .trap_vec_q(trap_vec_q), .redirect_q(redirect_q));
`default_nettype wire

// ===== testbench/ietu_regfile_model.sv
`timescale 1ns/1ns
`default_nettype none
module ietu_regfile_model (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic result_we_q,
  input wire logic [31:0] result_operand_q,
  output logic [15:0] wr_count_q
);
  // register file side: counts the writes it accepts
  always @(posedge core_clk)
  begin
    if (!resetn)
      wr_count_q <= 16'h0000;
    else if (result_we_q)
      wr_count_q <= wr_count_q + 16'h0001;
  end
endmodule
`default_nettype wire

// ===== testbench/ietu_core_bench.sv
`timescale 1ns/1ns
`default_nettype none
`include "ietu_map.vh"
module ietu_core_bench;
  logic core_clk = 1'b0, resetn = 1'b0, issue_valid = 1'b0;
  logic imm_sel = 1'b0, user_mode = 1'b0;
  logic [7:0] opcode = 8'h00, imm8 = 8'h00, assert_vec = 8'h00;
  logic [31:0] src_a = 32'h0000_0000, src_b = 32'h0000_0000;
  logic [31:0] pc = 32'h0000_0000;
  logic [15:0] imm16 = 16'h0000;
  logic [4:0] funnel_count = 5'h00;
  logic [1:0] br_mode = 2'h0;
  logic v_sel = 1'b0, v_user = 1'b0;
  logic [7:0] v_imm8 = 8'h00, v_vec = 8'h00;
  logic [15:0] v_imm16 = 16'h0000;
  logic [4:0] v_fc = 5'h00;
  logic [1:0] v_br = 2'h0;
  wire done_q, result_we_q, trap_q, redirect_q;
  wire flag_c_q, flag_z_q, flag_n_q, flag_v_q;
  wire [31:0] result_operand_q, q_reg_q, redirect_pc_q;
  wire [7:0] trap_vec_q;
  wire [15:0] wr_count_q;
  int mismatches = 0;
  int num_checks = 0;
  ietu_core i_ietu_core (.core_clk(core_clk), .resetn(resetn),
    .issue_valid(issue_valid), .opcode(opcode),
    .first_source_operand(src_a), .second_source_operand(src_b),
    .imm8(imm8), .imm_sel(imm_sel), .imm16(imm16),
    .funnel_count(funnel_count), .br_mode(br_mode), .pc(pc),
    .user_mode(user_mode), .assert_vec(assert_vec), .done_q(done_q),
    .result_operand_q(result_operand_q), .result_we_q(result_we_q),
    .trap_q(trap_q), .trap_vec_q(trap_vec_q), .flag_c_q(flag_c_q),
    .flag_z_q(flag_z_q), .flag_n_q(flag_n_q), .flag_v_q(flag_v_q),
    .q_reg_q(q_reg_q), .redirect_q(redirect_q),
    .redirect_pc_q(redirect_pc_q));
  ietu_regfile_model i_ietu_regfile_model (.core_clk(core_clk),
    .resetn(resetn), .result_we_q(result_we_q),
    .result_operand_q(result_operand_q), .wr_count_q(wr_count_q));
  always #20 core_clk = ~core_clk;
  task automatic check_word(input string w, input [31:0] e, input [31:0] g);
    begin
      num_checks++;
      if (g !== e)
      begin
        mismatches++;
        $display("ERROR %s expected %h seen %h", w, e, g);
      end
    end
  endtask
  task automatic check_bit(input string w, input logic e, input logic g);
    begin
      num_checks++;
      if (g !== e)
      begin
        mismatches++;
        $display("ERROR %s expected %b seen %b", w, e, g);
      end
    end
  endtask
  task automatic complete_run;
    begin
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  function automatic [7:0] ar(input [1:0] k, input c, input [1:0] chk);
    ar = {`IETU_CLS_ARITH, k, c, chk};
  endfunction
  task automatic issue(input [7:0] op, input [31:0] a, input [31:0] b);
    begin
      @(posedge core_clk);
      issue_valid <= 1'b1;
      opcode <= op;
      src_a <= a;
      src_b <= b;
      imm_sel <= v_sel;
      imm8 <= v_imm8;
      imm16 <= v_imm16;
      funnel_count <= v_fc;
      br_mode <= v_br;
      pc <= 32'h0000_1000;
      user_mode <= v_user;
      assert_vec <= v_vec;
    end
  endtask
  task automatic run(input [7:0] op, input [31:0] a, input [31:0] b,
    input logic we, input logic tr);
    begin
      issue(op, a, b);
      @(posedge core_clk);
      issue_valid <= 1'b0;
      #1;
      check_bit("done", 1'b1, done_q);
      if (we !== 1'bx)
        check_bit("write", we, result_we_q);
      check_bit("trap", tr, trap_q);
    end
  endtask
  task automatic run_trap(input [7:0] op, input [31:0] a, input [31:0] b,
    input [7:0] vec);
    begin
      run(op, a, b, 1'b0, 1'b1);
      check_word("vector", {24'h00_0000, vec}, {24'h00_0000, trap_vec_q});
    end
  endtask
  task automatic t_arith;
    begin
      run(ar(`IETU_KIND_ADD, 0, 0), 32'hffff_ffff, 32'h0000_0001, 1, 0);
      check_word("add", 32'h0000_0000, result_operand_q);
      check_word("czv", 32'h0000_0006,
        {29'h0000_0000, flag_c_q, flag_z_q, flag_v_q});
      run(ar(`IETU_KIND_ADD, 1, 0), 32'h0000_0005, 32'h0000_0006, 1, 0);
      check_word("sum_with_carry", 32'h0000_000c, result_operand_q);
      run(ar(`IETU_KIND_SUB, 1, 0), 32'h0000_000a, 32'h0000_0003, 1, 0);
      check_word("difference_with_borrow", 32'h0000_0006, result_operand_q);
      run(ar(`IETU_KIND_SUB, 0, 0), 32'h0000_0003, 32'h0000_000a, 1, 0);
      check_word("sub", 32'hffff_fff9, result_operand_q);
      check_bit("borrow", 1'b0, flag_c_q);
      run(ar(`IETU_KIND_RSUB, 1, 0), 32'h0000_0003, 32'h0000_000a, 1, 0);
      check_word("rsubc", 32'h0000_0006, result_operand_q);
      v_sel = 1'b1;
      v_imm8 = 8'hff;
      run(ar(`IETU_KIND_ADD, 0, 0), 32'h0000_0001, 32'hdead_beef, 1, 0);
      check_word("imm add", 32'h0000_0100, result_operand_q);
      v_sel = 1'b0;
    end
  endtask
  task automatic t_range;
    logic [15:0] n;
    begin
      @(posedge core_clk);
      #1;
      n = wr_count_q;
      run_trap(ar(0, 0, 1), 32'h7fff_ffff, 32'h0000_0001, 8'h02);
      run_trap(ar(1, 0, 1), 32'h8000_0000, 32'h0000_0001, 8'h02);
      run_trap(ar(0, 0, 2), 32'hffff_ffff, 32'h0000_0001, 8'h02);
      run_trap(ar(1, 0, 2), 32'h0000_0001, 32'h0000_0002, 8'h02);
      run_trap(ar(2, 0, 2), 32'h0000_0002, 32'h0000_0001, 8'h02);
      @(posedge core_clk);
      #1;
      check_word("writes", {16'h0000, n}, {16'h0000, wr_count_q});
      run(ar(2, 0, 1), 32'h0000_0002, 32'h0000_0009, 1, 0);
      check_word("rsubs", 32'h0000_0007, result_operand_q);
    end
  endtask
  task automatic t_cmp;
    logic [9:0] truth;
    begin
      truth = 10'h296;
      for (int r = 0; r < 10; r++)
      begin
        run({`IETU_CLS_CMP, 1'b0, r[3:0]}, 32'hffff_ffff, 32'h1, 1, 0);
        check_word("cmp", truth[r] ? `IETU_TRUE : `IETU_FALSE,
          result_operand_q);
      end
      run({`IETU_CLS_CMP, 1'b0, `IETU_REL_BYTE}, 32'h1122_3344,
        32'h5522_6677, 1, 0);
      check_word("byte hit", `IETU_TRUE, result_operand_q);
      run({`IETU_CLS_CMP, 1'b0, `IETU_REL_BYTE}, 32'h1122_3344,
        32'h5566_7788, 1, 0);
      check_word("byte miss", `IETU_FALSE, result_operand_q);
    end
  endtask
  task automatic t_assert;
    logic [7:0] op;
    begin
      op = {`IETU_CLS_ASRT, 1'b0, `IETU_REL_EQ};
      v_vec = 8'h10;
      run_trap(op, 32'h1, 32'h2, 8'h10);
      v_user = 1'b1;
      run_trap(op, 32'h1, 32'h2, 8'h05);
      v_vec = 8'h40;
      run_trap(op, 32'h1, 32'h2, 8'h40);
      run(op, 32'h7, 32'h7, 1'b0, 0);
      v_user = 1'b0;
    end
  endtask
  task automatic t_logic;
    logic [31:0] a, b, e;
    begin
      a = 32'hf0f0_ff00;
      b = 32'hff00_f0f0;
      for (int i = 0; i < 7; i++)
      begin
        case (i)
          0: e = a & b;
          1: e = a & ~b;
          2: e = ~(a & b);
          3: e = a | b;
          4: e = ~(a | b);
          5: e = a ^ b;
          default: e = ~(a ^ b);
        endcase
        run({`IETU_CLS_LOGIC, i[4:0]}, a, b, 1, 0);
        check_word("logic", e, result_operand_q);
        check_bit("neg flag", e[31], flag_n_q);
      end
    end
  endtask
  task automatic t_shift_trap;
    logic [31:0] e [3];
    logic [4:0] ts [6];
    begin
      e = '{32'h8000_0000, 32'h0000_0001, 32'hffff_ffff};
      ts = '{5'h00, 5'h0f, 5'h10, 5'h17, 5'h18, 5'h1f};
      for (int i = 0; i < 3; i++)
      begin
        run({`IETU_CLS_SHIFT, 3'h0, i[1:0]}, 32'h8000_0001, 32'd31, 1, 0);
        check_word("shift", e[i], result_operand_q);
      end
      v_fc = 5'h04;
      run({`IETU_CLS_SHIFT, 3'h0, `IETU_SH_FUNNEL}, 32'h8000_0001,
        32'h8000_0001, 1, 0);
      check_word("rotate", 32'h0000_0018, result_operand_q);
      for (int i = 0; i < 6; i++)
        run_trap({`IETU_CLS_TRAP, ts[i]}, 32'h1, 32'h2, i < 2 ? 8'h03 :
          i < 4 ? 8'h04 : 8'h00);
      for (int s = 0; s < 7; s++)
        run({`IETU_CLS_STEP, s[4:0]}, 32'h3, 32'h5, 1'b1, 0);
      run({`IETU_CLS_STEP, `IETU_ST_QUOT_INIT}, 32'h9, 32'h4, 1, 0);
      check_word("div init q", 32'h0000_0004, q_reg_q);
    end
  endtask
  task automatic br(input [4:0] s, input [1:0] m, input [31:0] a,
    input [31:0] b, input [15:0] imm, input logic tk, input [31:0] tgt);
    begin
      v_br = m;
      v_imm16 = imm;
      issue({`IETU_CLS_CTL, s}, a, b);
      issue(ar(0, 0, 0), 32'h1, 32'h2);
      #1;
      check_bit("early", 1'b0, redirect_q);
      if (s == `IETU_CT_CALL)
        check_word("link", 32'h0000_1008, result_operand_q);
      @(posedge core_clk);
      issue_valid <= 1'b0;
      #1;
      check_bit("redirect", tk, redirect_q);
      check_word("slot", 32'h0000_0003, result_operand_q);
      if (tk)
        check_word("target", tgt, redirect_pc_q);
    end
  endtask
  task automatic t_branch;
    begin
      br(`IETU_CT_JUMP, 0, 0, 0, 16'h0040, 1, 32'h0000_0100);
      br(`IETU_CT_JUMP, 1, 0, 0, 16'hfffe, 1, 32'h0000_0ff8);
      br(`IETU_CT_JUMP, 2, 0, 32'h2000, 0, 1, 32'h0000_2000);
      br(`IETU_CT_JUMP_TRUE, 0, `IETU_TRUE, 0, 16'h0040, 1,
        32'h0000_0100);
      br(`IETU_CT_JUMP_TRUE, 0, 32'h7fff_ffff, 0, 16'h0040, 0, 0);
      br(`IETU_CT_JUMP_FALSE, 0, 0, 0, 16'h0080, 1, 32'h0000_0200);
      br(`IETU_CT_CALL, 0, 0, 0, 16'h0040, 1, 32'h0000_0100);
    end
  endtask
  initial
  begin
    repeat (5) @(posedge core_clk);
    resetn <= 1'b1;
    #1;
    check_word("reset vector", 0, {24'h00_0000, trap_vec_q});
    t_arith();
    t_range();
    t_cmp();
    t_assert();
    t_logic();
    t_shift_trap();
    t_branch();
    complete_run();
  end
  initial
  begin
    #(40 * 3000);
    mismatches++;
    complete_run();
  end
endmodule
`default_nettype wire
